// ===== dv/host_model.sv
// Host model driving the register port of the coefficient bank
`timescale 1ns/1ps
module host_model
	import paged_coef_pkg::*;
(
	input  wire logic  clk,
	input  wire byte_t rdata_r,
	output reg_req_t   req
);
	initial req = '0;
	task automatic wr(input logic [6:0] a, input byte_t d);
		@(posedge clk) req <= '{1'b1, 1'b0, a, d};
		@(posedge clk) req <= '0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [6:0] a, output byte_t d);
		@(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk) req <= '0;
		@(negedge clk) d = rdata_r;
	endtask
	task automatic set_page(input logic p, output byte_t back);
		wr(7'h00, {7'h00, p});
		rd(7'h00, back);
	endtask
	task automatic set_coef(input logic [6:0] a, input coef_t v);
		@(posedge clk) req <= '{1'b1, 1'b0, a, v[15:8]};
		@(posedge clk) req <= '{1'b1, 1'b0, a + 7'h01, v[7:0]};
		@(posedge clk) req <= '0;
		@(negedge clk);
	endtask
endmodule // host_model

// ===== dv/paged_regs_props.sv
// Concurrent checks on the ports of the coefficient bank
`timescale 1ns/1ps
module paged_regs_props
	import paged_coef_pkg::*;
(
	input wire logic       clk,
	input wire logic       rstn,
	input wire reg_req_t   req,
	input wire byte_t      rdata_r,
	input wire logic       rvalid_r,
	input wire logic       page_r,
	input wire coef_bank_t coefs,
	input wire byte_t      numerator_term_three_high_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire pg_wr = req.wr && req.addr == 7'h00;
	wire lo0 = req.wr && page_r && req.addr == 7'h02;
	sequence s_high; req.wr && page_r && req.addr == 7'h01; endsequence
	sequence s_pair; s_high ##1 lo0; endsequence
	property p_rvalid; req.rd |=> rvalid_r; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read unanswered");
	property p_rsvd; req.rd && !page_r && req.addr >= 7'h6e |=> rdata_r == 8'h00; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved not zero");
	property p_page; pg_wr |=> page_r == $past(req.wdata[0]); endproperty
	a_page: assert property (p_page) else $error("page not set");
	property p_keep; !pg_wr |=> $stable(page_r); endproperty
	a_keep: assert property (p_keep) else $error("page moved");
	property p_rst; $rose(rstn) |-> !page_r && coefs == 48'h6be39666675d
		&& numerator_term_three_high_r == 8'h6b; endproperty
	a_rst: assert property (p_rst) else $error("bad reset value");
	property p_nolow; !lo0 |=> $stable(coefs.numerator_term_zero); endproperty
	a_nolow: assert property (p_nolow) else $error("coef changed early");
	property p_pair; s_pair |=> coefs.numerator_term_zero ==
		{$past(req.wdata, 2), $past(req.wdata)}; endproperty
	a_pair: assert property (p_pair) else $error("pair not applied");
	property p_num3; req.wr && page_r && req.addr == 7'h07 |=>
		numerator_term_three_high_r == $past(req.wdata); endproperty
	a_num3: assert property (p_num3) else $error("num3 not written");
endmodule // paged_regs_props
bind paged_filter_coefficient_regs paged_regs_props i_paged_regs_props (
	.clk(clk), .rstn(rstn), .req(req), .rdata_r(rdata_r),
	.rvalid_r(rvalid_r), .page_r(page_r), .coefs(coefs),
	.numerator_term_three_high_r(numerator_term_three_high_r));

// ===== dv/tb_paged_filter_coefficient_regs.sv
// Self-checking bench for the paged coefficient register bank
`timescale 1ns/1ps
module tb_paged_filter_coefficient_regs
	import paged_coef_pkg::*;
;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	reg_req_t   req;
	byte_t      rdata_r;
	logic       rvalid_r;
	logic       page_r;
	coef_bank_t coefs;
	byte_t      n3_high;
	byte_t      got;
	int         n_mismatch = 0;
	int         checks = 0;
	int         cyc = 0;
	byte_t      rst_tab[7] = '{8'h6b, 8'he3, 8'h96, 8'h66, 8'h67, 8'h5d, 8'h6b};
	always #4 clk = ~clk;
	paged_filter_coefficient_regs i_paged_filter_coefficient_regs (
		.clk(clk), .rstn(rstn), .req(req), .rdata_r(rdata_r),
		.rvalid_r(rvalid_r), .page_r(page_r), .coefs(coefs),
		.numerator_term_three_high_r(n3_high));
	host_model i_host_model (.clk(clk), .rdata_r(rdata_r), .req(req));
	task automatic check(input string what, input logic [47:0] exp,
		input logic [47:0] seen);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic t_defaults();
		check("page", 0, page_r);
		i_host_model.rd(7'h6e, got);
		check("rsvd_first", 8'h00, got);
		check("rvalid", 1, rvalid_r);
		i_host_model.rd(7'h7f, got);
		check("rsvd_last", 8'h00, got);
		i_host_model.rd(7'h01, got);
		check("page0_addr1", 8'h00, got);
		i_host_model.set_page(1'b1, got);
		check("page_back", 8'h01, got);
		for (int i = 0; i < 7; i++) begin
			i_host_model.rd(7'(i + 1), got);
			check("reset_byte", rst_tab[i], got);
		end
	endtask
	task automatic t_pairs();
		i_host_model.set_coef(7'h01, -16'sd32768);
		i_host_model.set_coef(7'h05, 16'sd32767);
		i_host_model.set_coef(7'h03, -16'sd1);
		check("coefs", 48'h8000ffff7fff, coefs);
		check("sign", 1, coefs.numerator_term_one < 0);
		i_host_model.wr(7'h07, 8'ha5);
		check("num3_high", 8'ha5, n3_high);
		i_host_model.rd(7'h02, got);
		check("num0_low", 8'h00, got);
	endtask
	task automatic t_switch();
		i_host_model.set_page(1'b0, got);
		check("page_back0", 8'h00, got);
		check("page_zero", 0, page_r);
		i_host_model.wr(7'h02, 8'h11);
		check("p0_ignored", 48'h8000ffff7fff, coefs);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_defaults();
		t_pairs();
		t_switch();
		@(posedge clk) rstn <= 1'b0;
		@(negedge clk);
		check("rst_coefs", 48'h6be39666675d, coefs);
		@(posedge clk) rstn <= 1'b1;
		i_host_model.rd(7'h01, got);
		check("page0_after_rst", 8'h00, got);
		final_report();
	end
endmodule // tb_paged_filter_coefficient_regs

// ===== rtl/coef_pair.sv
// One coefficient: high and low byte registers plus the applied value
`timescale 1ns/1ps
`include "paged_coef_regs.svh"

module coef_pair
	import paged_coef_pkg::*;
#(
	parameter byte_t RESET_HIGH = 8'h00,
	parameter byte_t RESET_LOW  = 8'h00
) (
	input  wire logic  clk,
	input  wire logic  rstn,
	input  wire logic  wr_high,
	input  wire logic  wr_low,
	input  wire byte_t wdata,
	output byte_t      high_r,
	output byte_t      low_r,
	output coef_t      coef_r
);

	// ----------------------------------------------------------------
	// Byte registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			high_r <= RESET_HIGH;
		end else if (wr_high) begin
			high_r <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			low_r <= RESET_LOW;
		end else if (wr_low) begin
			low_r <= wdata;
		end
	end

	// ----------------------------------------------------------------
	// Applied value: moves only when the low byte completes the pair
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			coef_r <= coef_t'({RESET_HIGH, RESET_LOW});
		end else if (wr_low) begin
			coef_r <= coef_t'({high_r, wdata});
		end
	end

endmodule // coef_pair

// ===== rtl/paged_filter_coefficient_regs.sv
// Paged register bank holding left-channel effects filter coefficients
//
// Summary of operation
// - First-page 110-127 read zero, never written
// - Page bit D0 picks page for accesses
// - Page bit resets to zero, page 0
// - Page selector identical at offset 0, both pages
// - Coefficient is high byte, then low byte
// - Coefficient is signed two's complement sixteen bits
// - Reset values for numerator zero, one high
// - Reset values for num one low, two, three
`timescale 1ns/1ps
`include "paged_coef_regs.svh"

module paged_filter_coefficient_regs
	import paged_coef_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rstn,
	input  wire reg_req_t req,
	output byte_t         rdata_r,
	output logic          rvalid_r,
	output logic          page_r,
	output coef_bank_t    coefs,
	output byte_t         numerator_term_three_high_r
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic on_page1;
	logic hit_page;
	logic hit_rsvd;
	logic wr1;

	assign on_page1 = (page_r == `PAGE_ONE);
	assign hit_page = (req.addr == `ADDR_PAGE_SELECTOR);
	assign hit_rsvd = !on_page1 && (req.addr >= `ADDR_RSVD_FIRST) &&
	                  (req.addr <= `ADDR_RSVD_LAST);
	assign wr1      = req.wr && on_page1;

	// ----------------------------------------------------------------
	// Page selector
	// ----------------------------------------------------------------
	// Upper bits are not stored; they read back as zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			page_r <= `RST_PAGE_SELECTOR;
		end else if (req.wr && hit_page) begin
			page_r <= req.wdata[`PAGE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Coefficients (page 1)
	// ----------------------------------------------------------------
	byte_t n0_hi, n0_lo, n1_hi, n1_lo, n2_hi, n2_lo;

	coef_pair #(
		.RESET_HIGH (`RST_NUM0_HIGH),
		.RESET_LOW  (`RST_NUM0_LOW)
	) u_num0 (
		.clk     (clk),
		.rstn    (rstn),
		.wr_high (wr1 && req.addr == `ADDR_NUM0_HIGH),
		.wr_low  (wr1 && req.addr == `ADDR_NUM0_LOW),
		.wdata   (req.wdata),
		.high_r  (n0_hi),
		.low_r   (n0_lo),
		.coef_r  (coefs.numerator_term_zero)
	);

	coef_pair #(
		.RESET_HIGH (`RST_NUM1_HIGH),
		.RESET_LOW  (`RST_NUM1_LOW)
	) u_num1 (
		.clk     (clk),
		.rstn    (rstn),
		.wr_high (wr1 && req.addr == `ADDR_NUM1_HIGH),
		.wr_low  (wr1 && req.addr == `ADDR_NUM1_LOW),
		.wdata   (req.wdata),
		.high_r  (n1_hi),
		.low_r   (n1_lo),
		.coef_r  (coefs.numerator_term_one)
	);

	coef_pair #(
		.RESET_HIGH (`RST_NUM2_HIGH),
		.RESET_LOW  (`RST_NUM2_LOW)
	) u_num2 (
		.clk     (clk),
		.rstn    (rstn),
		.wr_high (wr1 && req.addr == `ADDR_NUM2_HIGH),
		.wr_low  (wr1 && req.addr == `ADDR_NUM2_LOW),
		.wdata   (req.wdata),
		.high_r  (n2_hi),
		.low_r   (n2_lo),
		.coef_r  (coefs.numerator_term_two)
	);

	// Its low byte lives outside this bank, so only the raw byte is exported
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			numerator_term_three_high_r <= `RST_NUM3_HIGH;
		end else if (wr1 && req.addr == `ADDR_NUM3_HIGH) begin
			numerator_term_three_high_r <= req.wdata;
		end
	end

	// ----------------------------------------------------------------
	// Read path: one cycle after the request
	// ----------------------------------------------------------------
	byte_t rdata_nxt;

	always_comb begin
		rdata_nxt = `READ_ZERO;
		if (hit_page) begin
			rdata_nxt = {7'h00, page_r};
		end else if (hit_rsvd) begin
			rdata_nxt = `READ_ZERO;
		end else if (on_page1) begin
			case (req.addr)
				`ADDR_NUM0_HIGH: rdata_nxt = n0_hi;
				`ADDR_NUM0_LOW:  rdata_nxt = n0_lo;
				`ADDR_NUM1_HIGH: rdata_nxt = n1_hi;
				`ADDR_NUM1_LOW:  rdata_nxt = n1_lo;
				`ADDR_NUM2_HIGH: rdata_nxt = n2_hi;
				`ADDR_NUM2_LOW:  rdata_nxt = n2_lo;
				`ADDR_NUM3_HIGH: rdata_nxt = numerator_term_three_high_r;
				default:         rdata_nxt = `READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_r  <= `READ_ZERO;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= req.rd;
			if (req.rd) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

endmodule // paged_filter_coefficient_regs

// ===== shared/paged_coef_pkg.sv
// Types shared by the paged coefficient register bank
package paged_coef_pkg;

	typedef logic [7:0]         byte_t;
	typedef logic signed [15:0] coef_t;

	// One register access from the serial control front end
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		byte_t      wdata;
	} reg_req_t;

	// Applied coefficients seen by the effects filter
	typedef struct packed {
		coef_t numerator_term_zero;
		coef_t numerator_term_one;
		coef_t numerator_term_two;
	} coef_bank_t;

endpackage

// ===== shared/paged_coef_regs.svh
// Register offsets, field positions and reset values of the paged bank
`ifndef PAGED_COEF_REGS_SVH
`define PAGED_COEF_REGS_SVH

// ----------------------------------------------------------------
// Offsets (same on both pages for the page selector)
// ----------------------------------------------------------------
`define ADDR_PAGE_SELECTOR     7'h00
`define ADDR_NUM0_HIGH         7'h01
`define ADDR_NUM0_LOW          7'h02
`define ADDR_NUM1_HIGH         7'h03
`define ADDR_NUM1_LOW          7'h04
`define ADDR_NUM2_HIGH         7'h05
`define ADDR_NUM2_LOW          7'h06
`define ADDR_NUM3_HIGH         7'h07
`define ADDR_RSVD_FIRST        7'h6e
`define ADDR_RSVD_LAST         7'h7f

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define PAGE_BIT               0
`define PAGE_ZERO              1'b0
`define PAGE_ONE               1'b1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PAGE_SELECTOR      1'b0
`define RST_NUM0_HIGH          8'h6b
`define RST_NUM0_LOW           8'he3
`define RST_NUM1_HIGH          8'h96
`define RST_NUM1_LOW           8'h66
`define RST_NUM2_HIGH          8'h67
`define RST_NUM2_LOW           8'h5d
`define RST_NUM3_HIGH          8'h6b
`define READ_ZERO              8'h00

`endif
